// >>> logic/cpw_params.svh
// Constants of the capture and PWM unit: bus offsets, field positions,
// mode codes, reset values and prescaler terminal counts.
// Assumes a 32-bit classic Wishbone bus with byte addresses on 6 bits.
//
// How it works
// - Prescaler counter cleared when off or not capturing.
// - Any reset clears the prescaler counter.
// - Prescale change between capture modes keeps counter.
// - Mode field gives three capture prescale choices: 1, 4, 16.
// - Capture takes a selectable 16-bit time base.
// - Time base clock: fast, quarter, oscillator, pin.
// - Fast-clocked time base holds during sleep.
// - External-clocked time base keeps capturing in sleep.
// - Timer select zero picks the period timer.
// - Period register sets the PWM period.
// - Three-bit mask enables any mix of shutdown sources, or none.
// - Shutdown drives A/C and B/D to programmed states.
// - Software forces shutdown through the event bit.
// - Two-bit field picks output arrangement and direction.
// - Mode field picks PWM output polarities.
// - Duty is ten bits: eight upper, two lower.
// - Half-bridge inserts programmable seven-bit dead band.
// - Each output has its own steering enable.
// - Restart enable leaves shutdown at a period wrap once cause ends.
`ifndef CPW_PARAMS_SVH
`define CPW_PARAMS_SVH

`define CPW_ADR_W      6
`define CPW_OFF_CTL    6'h00
`define CPW_OFF_VALL   6'h04
`define CPW_OFF_VALH   6'h08
`define CPW_OFF_TSEL   6'h0C
`define CPW_OFF_ASC    6'h10
`define CPW_OFF_DBC    6'h14
`define CPW_OFF_STR    6'h18
`define CPW_OFF_PER    6'h1C
`define CPW_OFF_PTC    6'h20
`define CPW_OFF_TBC    6'h24
`define CPW_OFF_STA    6'h28
`define CPW_OFF_TBV    6'h2C

`define CPW_CTL_MODE   3:0
`define CPW_CTL_PFX    3:2
`define CPW_CTL_DC     5:4
`define CPW_CTL_OC     7:6
`define CPW_ASC_EVT    7
`define CPW_ASC_SRC    6:4
`define CPW_ASC_AC     3:2
`define CPW_ASC_BD     1:0
`define CPW_DBC_RSEN   7
`define CPW_DBC_DLY    6:0
`define CPW_PTC_RUN    2
`define CPW_PTC_PS     1:0
`define CPW_TBC_RUN    0
`define CPW_TBC_SRC    2:1
`define CPW_STA_FLAG   0
`define CPW_STA_SHUT   1

`define CPW_PFX_CAP    2'h1
`define CPW_PFX_PWM    2'h3
`define CPW_M_FALL     4'h4
`define CPW_M_RISE4    4'h6
`define CPW_M_RISE16   4'h7
`define CPW_PSC_ONE    4'h0
`define CPW_PSC_DIV4   4'h3
`define CPW_PSC_DIV16  4'hF
`define CPW_PS_DIV1    2'h0
`define CPW_PS_DIV4    2'h1
`define CPW_TSEL_T2    2'h0
`define CPW_PC_LAST    2'h3
`define CPW_Q_LAST     2'h3
`define CPW_RST_PER    8'hFF

`endif

// >>> logic/cpw_pkg.sv
// Types of the capture and PWM unit: output arrangement, time base
// clock source and the packed state record of the unit.
// Assumes the constants header is included by the design files.
package cpw_pkg;

  typedef enum logic [1:0] {
    CPW_OC_SINGLE = 2'b00,
    CPW_OC_FWD    = 2'b01,
    CPW_OC_HALF   = 2'b10,
    CPW_OC_REV    = 2'b11
  } cpw_oc_t;

  typedef enum logic [1:0] {
    CPW_TB_FOSC4 = 2'b00,
    CPW_TB_FOSC  = 2'b01,
    CPW_TB_SOSC  = 2'b10,
    CPW_TB_PIN   = 2'b11
  } cpw_tbsrc_t;

  typedef struct packed {
    logic [7:0]  ctl;
    logic [15:0] val;
    logic [1:0]  tsel;
    logic [7:0]  asc;
    logic [7:0]  dbc;
    logic [3:0]  str;
    logic [7:0]  per;
    logic [2:0]  ptc;
    logic [2:0]  tbc;
    logic        flag;
    logic [15:0] tb;
    logic [1:0]  q;
    logic        cap_d;
    logic        ext_d;
    logic [3:0]  psc;
    logic [3:0]  pps;
    logic [9:0]  pc;
    logic [9:0]  duty;
    logic        pwm_d;
    logic [6:0]  db;
    logic [3:0]  po;
    logic [3:0]  oe;
    logic        ack;
    logic [31:0] dat;
  } cpw_state_t;

endpackage

// >>> logic/cpw_unit.sv
// Capture and enhanced PWM unit with a classic Wishbone register slave.
// Assumes all pin inputs are synchronous to clk_i and that sosc_tick_i
// is a one-cycle pulse per secondary oscillator period.
`timescale 1ns/100ps
`include "cpw_params.svh"

module cpw_unit (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [5:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 cap_pin_i,
  input  wire logic                 sleep_i,
  input  wire logic                 sosc_tick_i,
  input  wire logic                 tb_clk_pin_i,
  input  wire logic                 cmp1_i,
  input  wire logic                 cmp2_i,
  input  wire logic                 fault_n_i,
  output logic      [3:0]           pwm_o,
  output logic      [3:0]           pwm_oe_o
);
  import cpw_pkg::*;

  cpw_state_t st_r;
  cpw_state_t st_nxt;

  logic [3:0] mode;
  logic       cap_mode;
  logic       pwm_on;
  logic       cap_evt;
  logic [3:0] psc_term;
  logic       psc_fire;
  logic       tb_tick;
  logic       tmr_go;
  logic [3:0] pps_term;
  logic       ptick;
  logic       wrap;
  logic       raw;
  logic       cause;
  logic       req;
  logic       wr;
  cpw_oc_t    oc;
  cpw_tbsrc_t tbsrc;

  ////////////////////////////////////////////////////////////////////////
  // Decode of the present state.

  // Mode, capture edge qualification and the capture prescaler.
  assign mode     = st_r.ctl[`CPW_CTL_MODE];
  assign cap_mode = st_r.ctl[`CPW_CTL_PFX] == `CPW_PFX_CAP;
  assign pwm_on   = st_r.ctl[`CPW_CTL_PFX] == `CPW_PFX_PWM;
  assign cap_evt  = (mode == `CPW_M_FALL) ? (~cap_pin_i & st_r.cap_d)
                                          : (cap_pin_i & ~st_r.cap_d);
  assign psc_term = (mode == `CPW_M_RISE4)  ? `CPW_PSC_DIV4 :
                    (mode == `CPW_M_RISE16) ? `CPW_PSC_DIV16 : `CPW_PSC_ONE;
  assign psc_fire = cap_mode & cap_evt & (st_r.psc == psc_term);

  // Time base advance from one of four clock sources.
  assign tbsrc = cpw_tbsrc_t'(st_r.tbc[`CPW_TBC_SRC]);
  always_comb
  begin
    unique case (tbsrc)
      CPW_TB_FOSC4: tb_tick = ~sleep_i & (st_r.q == `CPW_Q_LAST);
      CPW_TB_FOSC:  tb_tick = ~sleep_i;
      CPW_TB_SOSC:  tb_tick = sosc_tick_i;
      CPW_TB_PIN:   tb_tick = tb_clk_pin_i & ~st_r.ext_d;
    endcase
  end

  // Period timer runs only when selected and started.
  assign tmr_go   = st_r.ptc[`CPW_PTC_RUN] & (st_r.tsel == `CPW_TSEL_T2);
  assign pps_term = (st_r.ptc[`CPW_PTC_PS] == `CPW_PS_DIV1) ? `CPW_PSC_ONE :
                    (st_r.ptc[`CPW_PTC_PS] == `CPW_PS_DIV4) ? `CPW_PSC_DIV4
                                                            : `CPW_PSC_DIV16;
  assign ptick    = tmr_go & (st_r.pps == pps_term);
  assign wrap     = st_r.pc == {st_r.per, `CPW_PC_LAST};
  assign raw      = st_r.pc < st_r.duty;
  assign cause    = |(st_r.asc[`CPW_ASC_SRC] & {~fault_n_i, cmp2_i, cmp1_i});
  assign oc       = cpw_oc_t'(st_r.ctl[`CPW_CTL_OC]);

  // Bus request decode; a write lands on the edge where ack is seen.
  assign req = wb_cyc_i & wb_stb_i;
  assign wr  = req & wb_we_i & st_r.ack & wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic of the whole unit.
  always_comb
  begin
    logic [3:0] act;
    logic [3:0] en;
    logic       dbz;
    logic       inv_ac;
    logic       inv_bd;
    act    = '0;
    en     = '0;
    dbz    = (raw == st_r.pwm_d) ? (st_r.db == '0)
                                 : (st_r.dbc[`CPW_DBC_DLY] == '0);
    inv_ac = mode[1];
    inv_bd = mode[0];
    st_nxt = st_r;
    if (ce_i)
    begin
      // Bus slave: answer every request once, unmapped reads give zero.
      st_nxt.ack = req & ~st_r.ack;
      if (req & ~st_r.ack)
      begin
        unique case (wb_adr_i)
          `CPW_OFF_CTL:  st_nxt.dat = {24'h0, st_r.ctl};
          `CPW_OFF_VALL: st_nxt.dat = {24'h0, st_r.val[7:0]};
          `CPW_OFF_VALH: st_nxt.dat = {24'h0, st_r.val[15:8]};
          `CPW_OFF_TSEL: st_nxt.dat = {30'h0, st_r.tsel};
          `CPW_OFF_ASC:  st_nxt.dat = {24'h0, st_r.asc};
          `CPW_OFF_DBC:  st_nxt.dat = {24'h0, st_r.dbc};
          `CPW_OFF_STR:  st_nxt.dat = {28'h0, st_r.str};
          `CPW_OFF_PER:  st_nxt.dat = {24'h0, st_r.per};
          `CPW_OFF_PTC:  st_nxt.dat = {29'h0, st_r.ptc};
          `CPW_OFF_TBC:  st_nxt.dat = {29'h0, st_r.tbc};
          `CPW_OFF_STA:  st_nxt.dat = {30'h0, st_r.asc[`CPW_ASC_EVT], st_r.flag};
          `CPW_OFF_TBV:  st_nxt.dat = {16'h0, st_r.tb};
          default:       st_nxt.dat = 32'h0;
        endcase
      end
      // Register writes from software.
      if (wr)
      begin
        unique case (wb_adr_i)
          `CPW_OFF_CTL:  st_nxt.ctl = wb_dat_i[7:0];
          `CPW_OFF_VALL: st_nxt.val[7:0] = wb_dat_i[7:0];
          `CPW_OFF_VALH: st_nxt.val[15:8] = wb_dat_i[7:0];
          `CPW_OFF_TSEL: st_nxt.tsel = wb_dat_i[1:0];
          `CPW_OFF_ASC:  st_nxt.asc = wb_dat_i[7:0];
          `CPW_OFF_DBC:  st_nxt.dbc = wb_dat_i[7:0];
          `CPW_OFF_STR:  st_nxt.str = wb_dat_i[3:0];
          `CPW_OFF_PER:  st_nxt.per = wb_dat_i[7:0];
          `CPW_OFF_PTC:  st_nxt.ptc = wb_dat_i[2:0];
          `CPW_OFF_TBC:  st_nxt.tbc = wb_dat_i[2:0];
          `CPW_OFF_STA:  st_nxt.flag = st_r.flag & ~wb_dat_i[`CPW_STA_FLAG];
          default:       st_nxt.ctl = st_r.ctl;
        endcase
      end

      // Time base counter and its quarter-rate divider.
      st_nxt.ext_d = tb_clk_pin_i;
      if (~sleep_i)
      begin
        st_nxt.q = st_r.q + 2'h1;
      end
      if (st_r.tbc[`CPW_TBC_RUN] & tb_tick)
      begin
        st_nxt.tb = st_r.tb + 16'h1;
      end

      // Capture prescaler; a mode change inside capture keeps the count.
      st_nxt.cap_d = cap_pin_i;
      if (~cap_mode)
      begin
        st_nxt.psc = '0;
      end
      else if (psc_fire)
      begin
        st_nxt.psc = '0;
      end
      else if (cap_evt)
      begin
        st_nxt.psc = st_r.psc + 4'h1;
      end
      // A capture beats a same-cycle software write or flag clear.
      if (psc_fire)
      begin
        st_nxt.val  = st_r.tb;
        st_nxt.flag = 1'b1;
      end

      // Period timer with prescaler; the duty is latched at each wrap.
      if (ptick)
      begin
        st_nxt.pps = '0;
        if (wrap)
        begin
          st_nxt.pc   = '0;
          st_nxt.duty = {st_r.val[7:0], st_r.ctl[`CPW_CTL_DC]};
        end
        else
        begin
          st_nxt.pc = st_r.pc + 10'h1;
        end
      end
      else if (tmr_go)
      begin
        st_nxt.pps = st_r.pps + 4'h1;
      end

      // Shutdown: cause sets the event, restart clears it at a wrap.
      if (ptick & wrap & st_r.dbc[`CPW_DBC_RSEN] & ~cause)
      begin
        st_nxt.asc[`CPW_ASC_EVT] = 1'b0;
      end
      if (cause)
      begin
        st_nxt.asc[`CPW_ASC_EVT] = 1'b1;
      end

      // Dead band counter reloads on each change of the raw waveform; the
      // edge cycle itself is the first dead cycle, so delay zero means none.
      st_nxt.pwm_d = raw;
      if (raw != st_r.pwm_d)
      begin
        st_nxt.db = (st_r.dbc[`CPW_DBC_DLY] == '0) ? '0 : st_r.dbc[`CPW_DBC_DLY] - 7'h1;
      end
      else if (st_r.db != '0)
      begin
        st_nxt.db = st_r.db - 7'h1;
      end

      // Output arrangement, steering and polarity; pin 0 is A, 3 is D.
      unique case (oc)
        CPW_OC_SINGLE:
        begin
          act = {4{raw}};
          en  = st_r.str;
        end
        CPW_OC_FWD:
        begin
          act = {raw, 1'b0, 1'b0, 1'b1};
          en  = 4'hF;
        end
        CPW_OC_HALF:
        begin
          act = {1'b0, 1'b0, ~raw & dbz, raw & dbz};
          en  = 4'h3;
        end
        CPW_OC_REV:
        begin
          act = {1'b0, 1'b1, raw, 1'b0};
          en  = 4'hF;
        end
      endcase
      st_nxt.po = act ^ {inv_bd, inv_ac, inv_bd, inv_ac};
      st_nxt.oe = en;
      if (st_r.asc[`CPW_ASC_EVT])
      begin
        st_nxt.po = {st_r.asc[0], st_r.asc[2], st_r.asc[0], st_r.asc[2]};
        st_nxt.oe = {~st_r.asc[1], ~st_r.asc[3], ~st_r.asc[1], ~st_r.asc[3]};
      end
      if (~pwm_on)
      begin
        st_nxt.po = '0;
        st_nxt.oe = '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; any reset clears every field but the period, which loads FF.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r     <= '0;
      st_r.per <= `CPW_RST_PER;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign wb_dat_o = st_r.dat;
  assign wb_ack_o = st_r.ack;
  assign pwm_o    = st_r.po;
  assign pwm_oe_o = st_r.oe;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the unit's behaviour.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_fire;
    ce_i && psc_fire;
  endsequence

  sequence s_copied;
    st_r.flag && (st_r.val == $past(st_r.tb));
  endsequence

  // Capture path checks.
  a_psc_off_clear: assert property (ce_i && !cap_mode |=> st_r.psc == '0)
    else $error("prescaler not cleared outside capture");
  a_psc_reset_zero: assert property ($fell(rst_i) |-> st_r.psc == '0)
    else $error("prescaler not zero after reset");
  a_psc_keep_count: assert property (ce_i && cap_mode && !cap_evt |=>
                                     st_r.psc == $past(st_r.psc))
    else $error("prescaler changed without an edge");
  a_capture_copy: assert property (s_fire |=> s_copied)
    else $error("capture did not copy time base");

  // The prescaler restarts after each capture.
  a_psc_fire_clear: assert property (s_fire |=> st_r.psc == '0)
    else $error("prescaler not restarted after capture");

  // Time base and period timer checks.
  a_tb_sleep_hold: assert property (ce_i && sleep_i && !tbsrc[1] |=>
                                    st_r.tb == $past(st_r.tb))
    else $error("time base moved during sleep");
  a_tsel_stops: assert property (ce_i && st_r.tsel != `CPW_TSEL_T2 |=>
                                 st_r.pc == $past(st_r.pc))
    else $error("period timer ran while not selected");
  a_period_wrap: assert property (ce_i && ptick && wrap |=> st_r.pc == '0)
    else $error("period timer did not wrap at period");

  // The quarter-rate source holds the time base between its ticks.
  a_tb_quarter: assert property (ce_i && st_r.tbc[`CPW_TBC_RUN] &&
                                 tbsrc == CPW_TB_FOSC4 && st_r.q != `CPW_Q_LAST |=>
                                 st_r.tb == $past(st_r.tb))
    else $error("time base moved between quarter ticks");

  // An oscillator tick advances the time base by one.
  a_tb_ext_count: assert property (ce_i && st_r.tbc[`CPW_TBC_RUN] &&
                                   tbsrc == CPW_TB_SOSC && sosc_tick_i |=>
                                   st_r.tb == $past(st_r.tb) + 16'h1)
    else $error("time base missed an oscillator tick");

  // The duty is taken from the value and control registers at a wrap.
  a_duty_latch: assert property (ce_i && ptick && wrap |=>
                                 st_r.duty[9:2] == $past(st_r.val[7:0]) &&
                                 st_r.duty[1:0] == $past(st_r.ctl[`CPW_CTL_DC]))
    else $error("duty not latched at wrap");

  // Output and shutdown checks.
  a_shut_drive: assert property (ce_i && pwm_on && st_r.asc[`CPW_ASC_EVT] |=>
                                 pwm_o[0] == $past(st_r.asc[2]) &&
                                 pwm_oe_o[1] == !$past(st_r.asc[1]))
    else $error("shutdown levels not driven");
  a_restart_hold: assert property (ce_i && st_r.asc[`CPW_ASC_EVT] &&
                                   !st_r.dbc[`CPW_DBC_RSEN] && !wr |=>
                                   st_r.asc[`CPW_ASC_EVT])
    else $error("shutdown left without software");
  a_dead_band: assert property (ce_i && mode == 4'hC && oc == CPW_OC_HALF &&
                                !st_r.asc[`CPW_ASC_EVT] && st_r.db != '0 |=>
                                pwm_o[1:0] == 2'h0)
    else $error("output active inside dead band");

  // A selected cause enters shutdown in the next cycle.
  a_shut_set: assert property (ce_i && cause |=> st_r.asc[`CPW_ASC_EVT])
    else $error("shutdown cause ignored");

  // With restart enabled, a wrap without cause leaves shutdown.
  a_auto_restart: assert property (ce_i && ptick && wrap && st_r.dbc[`CPW_DBC_RSEN] &&
                                   !cause |=> !st_r.asc[`CPW_ASC_EVT])
    else $error("shutdown not left at wrap");

  // Single output mode enables exactly the steered pins.
  a_steer_enable: assert property (ce_i && pwm_on && oc == CPW_OC_SINGLE &&
                                   !st_r.asc[`CPW_ASC_EVT] |=> pwm_oe_o == $past(st_r.str))
    else $error("output enables differ from steering");

  // Forward full bridge enables all pins and holds A at its active level.
  a_fwd_active: assert property (ce_i && pwm_on && oc == CPW_OC_FWD &&
                                 !st_r.asc[`CPW_ASC_EVT] |=>
                                 pwm_oe_o == 4'hF && pwm_o[0] == !$past(mode[1]))
    else $error("forward bridge output A not active");

  // Outside PWM mode every output is low and released.
  a_idle_outputs: assert property (ce_i && !pwm_on |=> pwm_o == 4'h0 && pwm_oe_o == 4'h0)
    else $error("outputs driven outside PWM mode");

  // Bus and clock enable checks.
  a_bus_ack_once: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // A low clock enable freezes every state field.
  a_ce_freeze: assert property (!ce_i |=> st_r == $past(st_r))
    else $error("state moved while clock enable low");

endmodule

// >>> tb/cpw_far_side.sv
// Far-side model: capture pin, time base clock sources, bridge monitor.
// Assumes the bench calls its tasks and that it shares the unit clock.
`timescale 1ns/100ps

module cpw_far_side (
  input  wire logic       clk_i,
  input  wire logic [3:0] pwm_i,
  input  wire logic [3:0] pwm_oe_i,
  output logic            cap_o,
  output logic            sosc_o,
  output logic            pin_o
);
  int hi [4];
  int both;

  // Pins idle low until a task moves them.
  initial
  begin
    cap_o = 1'b0;
    sosc_o = 1'b0;
    pin_o = 1'b0;
  end

  // Per count, one rising and one falling capture edge; high held 3 cycles, low 4 or more.
  task automatic edges(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      cap_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      cap_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask

  // Oscillator pulses or pin edges for the time base.
  task automatic ticks(input bit pin, input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      if (pin)
        pin_o <= 1'b1;
      else
        sosc_o <= 1'b1;
      @(posedge clk_i);
      pin_o <= 1'b0;
      sosc_o <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask

  // Counts driven-high cycles per pin and A/B overlap of the bridge.
  task automatic measure(input int n);
    hi = '{0, 0, 0, 0};
    both = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      for (int i = 0; i < 4; i++)
        hi[i] += int'(pwm_oe_i[i] === 1'b1 && pwm_i[i] === 1'b1);
      both += int'(pwm_i[1:0] === 2'b11 && pwm_oe_i[1:0] === 2'b11);
    end
  endtask
endmodule

// >>> tb/cpw_unit_test.sv
// Self-checking bench of the capture and PWM unit.
// Assumes the register map of the constants header and one-cycle acks.
`timescale 1ns/100ps
`include "cpw_params.svh"

module cpw_unit_test;
  import cpw_pkg::*;

  logic        clk_i, rst_i, ce_i, sleep_i, cmp1_i, cmp2_i, fault_n_i;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        cap_pin_i, sosc_tick_i, tb_clk_pin_i;
  logic [5:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, pwm_o, pwm_oe_o, sel_v;
  logic [31:0] wb_dat_i, wb_dat_o, rv, x;
  int          fails, check_count;

  cpw_unit dut (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cap_pin_i, .sleep_i, .sosc_tick_i,
    .tb_clk_pin_i, .cmp1_i, .cmp2_i, .fault_n_i, .pwm_o, .pwm_oe_o);

  cpw_far_side far (.clk_i, .pwm_i(pwm_o), .pwm_oe_i(pwm_oe_o), .cap_o(cap_pin_i),
    .sosc_o(sosc_tick_i), .pin_o(tb_clk_pin_i));

  // 100 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      fails++;
    end
  endtask

  // Classic cycle held until ack is sampled high; read data taken there.
  task automatic bus(input logic we, input logic [5:0] adr, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= sel_v;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rv = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      chk("bus ack", 32'h1, {31'h0, wb_ack_o});
      results();
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic see(input string what, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(what, e, rv);
  endtask

  task automatic cause(input logic [2:0] c);
    @(posedge clk_i);
    cmp1_i    <= c[0];
    cmp2_i    <= c[1];
    fault_n_i <= ~c[2];
  endtask

  ////////////////////////////////////////
  task automatic t_reset();
    see("control", `CPW_OFF_CTL, 32'h0);
    see("period", `CPW_OFF_PER, 32'hFF);
    see("status", `CPW_OFF_STA, 32'h0);
    see("unmapped", 6'h30, 32'h0);
    sel_v = 4'hE;
    wr(`CPW_OFF_PER, 8'h55);
    sel_v = 4'hF;
    see("write without lane 0", `CPW_OFF_PER, 32'hFF);
    $display("test reset done");
  endtask

  task automatic t_prescale();
    logic [3:0] m [4] = '{`CPW_M_FALL, 4'h5, `CPW_M_RISE4, `CPW_M_RISE16};
    int         k [4] = '{1, 1, 4, 16};
    for (int i = 0; i < 4; i++)
    begin
      wr(`CPW_OFF_CTL, 8'h00);
      wr(`CPW_OFF_CTL, {4'h0, m[i]});
      far.edges(k[i] - 1);
      see("flag early", `CPW_OFF_STA, 32'h0);
      far.edges(1);
      see("flag", `CPW_OFF_STA, 32'h1);
      wr(`CPW_OFF_STA, 8'h01);
    end
    see("flag cleared", `CPW_OFF_STA, 32'h0);
    far.edges(3);
    wr(`CPW_OFF_CTL, 8'h00);
    wr(`CPW_OFF_CTL, {4'h0, `CPW_M_RISE4});
    far.edges(1);
    see("off clears count", `CPW_OFF_STA, 32'h0);
    far.edges(2);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_reset();
    wr(`CPW_OFF_CTL, {4'h0, `CPW_M_RISE4});
    far.edges(1);
    see("reset clears count", `CPW_OFF_STA, 32'h0);
    $display("test prescale done");
  endtask

  task automatic t_value();
    wr(`CPW_OFF_TBC, 8'h03);
    repeat (50) @(posedge clk_i);
    wr(`CPW_OFF_TBC, 8'h02);
    bus(1'b0, `CPW_OFF_TBV, 8'h00);
    x = rv;
    wr(`CPW_OFF_CTL, 8'h00);
    wr(`CPW_OFF_CTL, 8'h05);
    far.edges(1);
    see("value low", `CPW_OFF_VALL, {24'h0, x[7:0]});
    see("value high", `CPW_OFF_VALH, {24'h0, x[15:8]});
    wr(`CPW_OFF_STA, 8'h01);
    see("capture flag cleared", `CPW_OFF_STA, 32'h0);
    $display("test capture value done");
  endtask

  task automatic t_sleep();
    wr(`CPW_OFF_TBC, 8'h01);
    bus(1'b0, `CPW_OFF_TBV, 8'h00);
    x = rv;
    repeat (41) @(posedge clk_i);
    see("quarter rate", `CPW_OFF_TBV, x + 32'd11);
    wr(`CPW_OFF_TBC, 8'h03);
    bus(1'b0, `CPW_OFF_TBV, 8'h00);
    x = rv;
    @(posedge clk_i);
    ce_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    ce_i <= 1'b1;
    see("enable freezes", `CPW_OFF_TBV, x + 32'd4);
    @(posedge clk_i);
    sleep_i <= 1'b1;
    wr(`CPW_OFF_TBC, 8'h03);
    bus(1'b0, `CPW_OFF_TBV, 8'h00);
    x = rv;
    repeat (20) @(posedge clk_i);
    see("held in sleep", `CPW_OFF_TBV, x);
    for (int p = 0; p < 2; p++)
    begin
      wr(`CPW_OFF_TBC, p ? 8'h07 : 8'h05);
      bus(1'b0, `CPW_OFF_TBV, 8'h00);
      x = rv;
      far.ticks(p[0], 5);
      see("counts in sleep", `CPW_OFF_TBV, x + 32'h5);
    end
    @(posedge clk_i);
    sleep_i <= 1'b0;
    $display("test sleep done");
  endtask

  // Period 4 x (3 + 1) = 16 clocks, duty {02, 01} = 9 clocks.
  task automatic cfg(input logic [7:0] ctl, input logic [3:0] str);
    wr(`CPW_OFF_PER, 8'h03);
    wr(`CPW_OFF_PTC, 8'h04);
    wr(`CPW_OFF_VALL, 8'h02);
    wr(`CPW_OFF_CTL, ctl);
    wr(`CPW_OFF_STR, str);
    repeat (40) @(posedge clk_i);
    far.measure(32);
  endtask

  task automatic t_pwm();
    wr(`CPW_OFF_DBC, 8'h03);
    cfg(8'h1C, 4'h1);
    chk("A duty", 32'd18, far.hi[0]);
    chk("enables A", 32'h1, {28'h0, pwm_oe_o});
    cfg(8'h1E, 4'h1);
    chk("A active low", 32'd14, far.hi[0]);
    cfg(8'h1C, 4'h2);
    chk("enables B", 32'h2, {28'h0, pwm_oe_o});
    chk("B duty", 32'd18, far.hi[1]);
    cfg(8'h5C, 4'hF);
    chk("fwd A", 32'd32, far.hi[0]);
    chk("fwd D", 32'd18, far.hi[3]);
    cfg(8'hDC, 4'hF);
    chk("rev C", 32'd32, far.hi[2]);
    chk("rev B", 32'd18, far.hi[1]);
    cfg(8'h9C, 4'hF);
    chk("half A", 32'd12, far.hi[0]);
    chk("half B", 32'd8, far.hi[1]);
    chk("overlap", 32'd0, far.both);
    wr(`CPW_OFF_TSEL, 8'h01);
    repeat (8) @(posedge clk_i);
    far.measure(32);
    chk("frozen", 32'd0, far.hi[0] % 32);
    wr(`CPW_OFF_TSEL, 8'h00);
    $display("test pwm done");
  endtask

  task automatic t_shut();
    logic [7:0] code [3] = '{8'h14, 8'h21, 8'h44};
    cfg(8'h1C, 4'hF);
    for (int i = 0; i < 3; i++)
    begin
      wr(`CPW_OFF_ASC, code[i]);
      cause(3'b001 << i);
      repeat (4) @(posedge clk_i);
      far.measure(32);
      chk("A/C state", code[i][3:2] == 2'b01 ? 32'd32 : 32'd0, far.hi[0]);
      chk("B/D state", code[i][1:0] == 2'b01 ? 32'd32 : 32'd0, far.hi[1]);
      cause(3'b000);
      repeat (40) @(posedge clk_i);
      see("held shut", `CPW_OFF_STA, 32'h2);
      wr(`CPW_OFF_ASC, code[i]);
      repeat (4) @(posedge clk_i);
      see("resumed", `CPW_OFF_STA, 32'h0);
    end
    wr(`CPW_OFF_DBC, 8'h83);
    cause(3'b100);
    repeat (4) @(posedge clk_i);
    see("auto shut", `CPW_OFF_STA, 32'h2);
    cause(3'b000);
    repeat (40) @(posedge clk_i);
    see("auto restart", `CPW_OFF_STA, 32'h0);
    wr(`CPW_OFF_DBC, 8'h03);
    wr(`CPW_OFF_ASC, 8'h84);
    repeat (4) @(posedge clk_i);
    see("forced", `CPW_OFF_STA, 32'h2);
    far.measure(32);
    chk("forced A", 32'd32, far.hi[0]);
    $display("test shutdown done");
  endtask

  ////////////////////////////////////////
  // Idle inputs, 12 reset cycles, then the scenarios.
  initial
  begin
    {rst_i, ce_i, fault_n_i} = 3'b111;
    {sleep_i, cmp1_i, cmp2_i, wb_cyc_i, wb_stb_i, wb_we_i} = 6'h00;
    wb_adr_i = 6'h00;
    wb_sel_i = 4'hF;
    sel_v = 4'hF;
    wb_dat_i = 32'h0;
    fails = 0;
    check_count = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_prescale();
    t_value();
    t_sleep();
    t_pwm();
    t_shut();
    results();
  end
endmodule
